// ### rtl/port2_phy_pkg.sv
// Purpose: Shared constants for the port 2 transceiver status and advertisement words.
// Assumes: Byte offsets in the host register space; each word is 16 bits wide.
// Notes:   Bit positions are indices into a 16-bit word.
package port2_phy_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Byte offsets of the words in the host register space.
    localparam logic [7:0] OFS_BASIC_STATUS  = 8'h5A;
    localparam logic [7:0] OFS_IDENT_LOW     = 8'h5C;
    localparam logic [7:0] OFS_IDENT_HIGH    = 8'h5E;
    localparam logic [7:0] OFS_ADVERT        = 8'h60;
    localparam logic [7:0] OFS_PARTNER       = 8'h62;
    localparam logic [7:0] OFS_RESERVED_LOC  = 8'h64;

    ////////////////////////////////////////////////////////////////////////////
    // Basic status word bit positions.
    localparam int BS_T4_CAPABLE    = 15;
    localparam int BS_100_FULL      = 14;
    localparam int BS_100_HALF      = 13;
    localparam int BS_10_FULL       = 12;
    localparam int BS_10_HALF       = 11;
    localparam int BS_PREAMBLE_SUP  = 6;
    localparam int BS_AN_COMPLETE   = 5;
    localparam int BS_AN_CAPABLE    = 3;
    localparam int BS_LINK_UP       = 2;
    localparam int BS_JABBER        = 1;
    localparam int BS_EXTENDED      = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Advertisement and partner ability word bit positions.
    localparam int AB_NEXT_PAGE     = 15;
    localparam int AB_ACK           = 14;
    localparam int AB_REMOTE_FAULT  = 13;
    localparam int AB_PAUSE         = 10;
    localparam int AB_RSVD9         = 9;
    localparam int AB_100_FULL      = 8;
    localparam int AB_100_HALF      = 7;
    localparam int AB_10_FULL       = 6;
    localparam int AB_10_HALF       = 5;
    localparam int AB_SEL_MSB       = 4;
    localparam int AB_SEL_LSB       = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Port 2 status word mirror positions, low seven bits.
    localparam int SW_AN_COMPLETE   = 6;
    localparam int SW_LINK_UP       = 5;
    localparam int SW_PARTNER_PAUSE = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Fixed field values and reset values.
    localparam logic [4:0]  SELECTOR_VALUE   = 5'h01;
    localparam logic [4:0]  PARTNER_LOW_BITS = 5'h01;
    localparam logic [4:0]  ADV_RESET        = 5'h1F;
    localparam logic        RSVD9_RESET      = 1'b0;
    localparam logic [15:0] WORD_ZERO        = 16'h0000;
    localparam logic [6:0]  MIRROR_RESET     = 7'h00;
    localparam logic [4:0]  ABILITY_RESET    = 5'h00;
    localparam logic        BIT_ONE          = 1'b1;
    localparam logic        BIT_ZERO         = 1'b0;

    // True when a byte address falls on the given 16-bit word.
    function automatic logic wordHit(input logic [7:0] addr, input logic [7:0] ofs);
        wordHit = (addr[7:1] == ofs[7:1]);
    endfunction

endpackage

// ### rtl/adv_store_if.sv
// Purpose: Carries advertisement writes and the stored bits between decode and storage.
// Assumes: All signals are on clk_sys.
// Notes:   advBits order is pause, 100 full, 100 half, 10 full, 10 half.
`timescale 1ns/1ps
`default_nettype none
interface adv_store_if;
    logic        hostWr;
    logic [1:0]  hostBe;
    logic [15:0] hostData;
    logic        cw4Wr;
    logic [4:0]  cw4Data;
    logic [4:0]  advBits;
    logic        rsvd9;

    modport ctrl (
        output hostWr,
        output hostBe,
        output hostData,
        output cw4Wr,
        output cw4Data,
        input  advBits,
        input  rsvd9
    );

    modport store (
        input  hostWr,
        input  hostBe,
        input  hostData,
        input  cw4Wr,
        input  cw4Data,
        output advBits,
        output rsvd9
    );
endinterface
`default_nettype wire

// ### rtl/advert_store.sv
// Purpose: One storage element per writable advertisement bit; pause and ability bits shared by two write paths, bit 9 host only.
// Assumes: Host and control word 4 writes arrive on clk_sys.
// Notes:   A host write in the same cycle as a control word 4 write wins.
`timescale 1ns/1ps
`default_nettype none
module advert_store
    import port2_phy_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_sys,
    input  wire logic     rstn,
    // Storage port
    adv_store_if.store    st
);

    logic [4:0] advReg;
    logic [4:0] advNext;
    logic       rsvd9Reg;
    logic       rsvd9Next;
    logic [4:0] hostVal;
    logic       hiLane;
    logic       loLane;

    ////////////////////////////////////////////////////////////////////////////
    // Byte lane merge of a host write; only writable bits are picked out.
    assign hiLane = st.hostWr & st.hostBe[1];
    assign loLane = st.hostWr & st.hostBe[0];

    assign hostVal[4] = hiLane ? st.hostData[AB_PAUSE]    : advReg[4]; // RQ9
    assign hostVal[3] = hiLane ? st.hostData[AB_100_FULL] : advReg[3]; // RQ10
    assign hostVal[2] = loLane ? st.hostData[AB_100_HALF] : advReg[2]; // RQ10
    assign hostVal[1] = loLane ? st.hostData[AB_10_FULL]  : advReg[1]; // RQ10
    assign hostVal[0] = loLane ? st.hostData[AB_10_HALF]  : advReg[0]; // RQ10

    assign advNext   = st.hostWr ? hostVal : (st.cw4Wr ? st.cw4Data : advReg); // RQ19
    assign rsvd9Next = hiLane ? st.hostData[AB_RSVD9] : rsvd9Reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            advReg   <= ADV_RESET; // RQ9 RQ10
            rsvd9Reg <= RSVD9_RESET; // RQ12
        end else begin
            advReg   <= advNext;
            rsvd9Reg <= rsvd9Next;
        end
    end

    assign st.advBits = advReg; // RQ19
    assign st.rsvd9   = rsvd9Reg;

endmodule // advert_store
`default_nettype wire

// ### rtl/port2_phy_regs.sv
// Purpose: Status, identifier, advertisement and partner ability words of port 2.
// Assumes: Status inputs come from transceiver logic on clk_sys; no synchroniser.
// Notes:   Reads return data one cycle after the read strobe, with regRdValid.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RQ1] Basic status bit 15 reads 0: no 100BASE-T4.
// [RQ2] Basic status bits 14 to 11 read 1: TX and 10BASE-T duplex modes.
// [RQ3] Bit 5 shows negotiation complete; mirrored to status word bit 6.
// [RQ4] Bit 2 shows link up; mirrored to status word bit 5.
// [RQ5] Bit 3 reads constant 1: able to auto-negotiate.
// [RQ6] Bit 0 reads 0: no extended registers.
// [RQ7] Bits 6, 1 and reserved 10 to 7 read 0.
// [RQ8] Identifier low word at 0x05C, high word at 0x05E, read only.
// [RQ9] Advert bit 10 pause, writable, reset 1, shared with control word bit 4.
// [RQ10] Advert bits 8 to 5 writable, reset 1, shared with control bits 3 to 0.
// [RQ11] Advert bits 4 to 0 read the selector value 0x01.
// [RQ12] Advert bits 15 to 11 read 0; bit 9 resets to 0.
// [RQ13] Partner bit 10 shows partner pause, reset 0; mirrored to status bit 4.
// [RQ14] Partner bits 8 to 5 show partner abilities; mirrored to status bits 3-0.
// [RQ15] Partner bits 15 to 11 and 9 read 0.
// [RQ16] Location after the partner word is reserved and reads 0.
// [RQ17] Advertised abilities are used only while negotiation is enabled.
// [RQ18] Writes to read-only and reserved fields change nothing. Reserved advert bit 9 is stored by host writes and reads back.
// [RQ19] Advert bits and control word 4 bits are one storage element.
module port2_phy_regs
    import port2_phy_pkg::*;
#(
    // Identifier values; the defaults are arbitrary.
    parameter logic [15:0] IDENT_LOW_VALUE  = 16'hA5A5,
    parameter logic [15:0] IDENT_HIGH_VALUE = 16'h5A5A
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Host register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [1:0]  regBe,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData,
    output logic             regRdValid,
    // Transceiver status
    input  wire logic        anComplete,
    input  wire logic        linkUp,
    input  wire logic        partnerPause,
    input  wire logic [3:0]  partnerAbility,
    input  wire logic        anEnable,
    // Control word 4 shared bits
    input  wire logic        cw4WrEn,
    input  wire logic [4:0]  cw4WrData,
    output logic      [4:0]  cw4AdvBits,
    // Derived outputs
    output logic      [6:0]  statusWordMirror,
    output logic      [4:0]  advertToAn
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    adv_store_if advIf ();

    logic        anCompleteReg;
    logic        linkUpReg;
    logic        partnerPauseReg;
    logic [3:0]  partnerAbilityReg;
    logic [6:0]  mirrorNext;
    logic [4:0]  advertAnNext;

    logic        hitBasic;
    logic        hitIdLow;
    logic        hitIdHigh;
    logic        hitAdvert;
    logic        hitPartner;
    logic        hitReserved;
    logic        anyBe;
    logic        advertWr;

    logic [15:0] basicWord;
    logic [15:0] advertWord;
    logic [15:0] partnerWord;
    logic [15:0] rdSel;
    logic [15:0] rdNext;
    logic        rdValidNext;

    logic        bsAnComplete;
    logic        bsLinkUp;
    logic        lpPause;
    logic        lp100Full;
    logic        lp100Half;
    logic        lp10Full;
    logic        lp10Half;

    ////////////////////////////////////////////////////////////////////////////
    // Capture of transceiver status into flip-flops.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            anCompleteReg     <= BIT_ZERO;
            linkUpReg         <= BIT_ZERO;
            partnerPauseReg   <= BIT_ZERO;
            partnerAbilityReg <= ABILITY_RESET[3:0];
        end else begin
            anCompleteReg     <= anComplete; // RQ3
            linkUpReg         <= linkUp; // RQ4
            partnerPauseReg   <= partnerPause; // RQ13
            partnerAbilityReg <= partnerAbility; // RQ14
        end
    end

    assign bsAnComplete = anCompleteReg;
    assign bsLinkUp     = linkUpReg;
    assign lpPause      = partnerPauseReg;
    assign lp100Full    = partnerAbilityReg[3];
    assign lp100Half    = partnerAbilityReg[2];
    assign lp10Full     = partnerAbilityReg[1];
    assign lp10Half     = partnerAbilityReg[0];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    assign hitBasic    = wordHit(regAddr, OFS_BASIC_STATUS);
    assign hitIdLow    = wordHit(regAddr, OFS_IDENT_LOW);
    assign hitIdHigh   = wordHit(regAddr, OFS_IDENT_HIGH);
    assign hitAdvert   = wordHit(regAddr, OFS_ADVERT);
    assign hitPartner  = wordHit(regAddr, OFS_PARTNER);
    assign hitReserved = wordHit(regAddr, OFS_RESERVED_LOC);
    assign anyBe       = |regBe;

    // Only the advertisement word has writable storage; other writes are dropped.
    assign advertWr = regWrEn & hitAdvert & anyBe; // RQ18

    ////////////////////////////////////////////////////////////////////////////
    // Advertisement storage, shared with control word 4.
    assign advIf.hostWr   = advertWr;
    assign advIf.hostBe   = regBe;
    assign advIf.hostData = regWrData;
    assign advIf.cw4Wr    = cw4WrEn; // RQ19
    assign advIf.cw4Data  = cw4WrData;

    advert_store u_advert_store (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .st      (advIf.store)
    );

    assign cw4AdvBits = advIf.advBits; // RQ19

    ////////////////////////////////////////////////////////////////////////////
    // Basic status word.
    always_comb begin
        basicWord                  = WORD_ZERO; // RQ7
        basicWord[BS_T4_CAPABLE]   = BIT_ZERO; // RQ1
        basicWord[BS_100_FULL]     = BIT_ONE; // RQ2
        basicWord[BS_100_HALF]     = BIT_ONE; // RQ2
        basicWord[BS_10_FULL]      = BIT_ONE; // RQ2
        basicWord[BS_10_HALF]      = BIT_ONE; // RQ2
        basicWord[BS_PREAMBLE_SUP] = BIT_ZERO; // RQ7
        basicWord[BS_AN_COMPLETE]  = bsAnComplete; // RQ3
        basicWord[BS_AN_CAPABLE]   = BIT_ONE; // RQ5
        basicWord[BS_LINK_UP]      = bsLinkUp; // RQ4
        basicWord[BS_JABBER]       = BIT_ZERO; // RQ7
        basicWord[BS_EXTENDED]     = BIT_ZERO; // RQ6
    end

    ////////////////////////////////////////////////////////////////////////////
    // Advertisement word as read back.
    always_comb begin
        advertWord                            = WORD_ZERO; // RQ12
        advertWord[AB_NEXT_PAGE]              = BIT_ZERO; // RQ12
        advertWord[AB_REMOTE_FAULT]           = BIT_ZERO; // RQ12
        advertWord[AB_PAUSE]                  = advIf.advBits[4]; // RQ9
        advertWord[AB_RSVD9]                  = advIf.rsvd9; // RQ12
        advertWord[AB_100_FULL]               = advIf.advBits[3]; // RQ10
        advertWord[AB_100_HALF]               = advIf.advBits[2]; // RQ10
        advertWord[AB_10_FULL]                = advIf.advBits[1]; // RQ10
        advertWord[AB_10_HALF]                = advIf.advBits[0]; // RQ10
        advertWord[AB_SEL_MSB:AB_SEL_LSB]     = SELECTOR_VALUE; // RQ11
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link partner ability word.
    always_comb begin
        partnerWord                           = WORD_ZERO; // RQ15
        partnerWord[AB_NEXT_PAGE]             = BIT_ZERO; // RQ15
        partnerWord[AB_ACK]                   = BIT_ZERO; // RQ15
        partnerWord[AB_REMOTE_FAULT]          = BIT_ZERO; // RQ15
        partnerWord[AB_PAUSE]                 = lpPause; // RQ13
        partnerWord[AB_RSVD9]                 = BIT_ZERO; // RQ15
        partnerWord[AB_100_FULL]              = lp100Full; // RQ14
        partnerWord[AB_100_HALF]              = lp100Half; // RQ14
        partnerWord[AB_10_FULL]               = lp10Full; // RQ14
        partnerWord[AB_10_HALF]               = lp10Half; // RQ14
        partnerWord[AB_SEL_MSB:AB_SEL_LSB]    = PARTNER_LOW_BITS;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; the reserved location and unmapped offsets read zero.
    assign rdSel = hitBasic    ? basicWord        :
                   hitIdLow    ? IDENT_LOW_VALUE  : // RQ8
                   hitIdHigh   ? IDENT_HIGH_VALUE : // RQ8
                   hitAdvert   ? advertWord       :
                   hitPartner  ? partnerWord      :
                   hitReserved ? WORD_ZERO        : // RQ16
                                 WORD_ZERO;

    assign rdNext      = regRdEn ? rdSel : regRdData;
    assign rdValidNext = regRdEn;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdData  <= WORD_ZERO;
            regRdValid <= BIT_ZERO;
        end else begin
            regRdData  <= rdNext;
            regRdValid <= rdValidNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word mirror and abilities handed to negotiation.
    always_comb begin
        mirrorNext                   = MIRROR_RESET;
        mirrorNext[SW_AN_COMPLETE]   = anCompleteReg; // RQ3
        mirrorNext[SW_LINK_UP]       = linkUpReg; // RQ4
        mirrorNext[SW_PARTNER_PAUSE] = partnerPauseReg; // RQ13
        mirrorNext[3:0]              = partnerAbilityReg; // RQ14
    end

    // With negotiation disabled nothing is advertised.
    assign advertAnNext = anEnable ? advIf.advBits : ABILITY_RESET; // RQ17

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            statusWordMirror <= MIRROR_RESET;
            advertToAn       <= ABILITY_RESET;
        end else begin
            statusWordMirror <= mirrorNext;
            advertToAn       <= advertAnNext;
        end
    end

endmodule // port2_phy_regs
`default_nettype wire

// ### verification/port2_phy_regs_sva.sv
// Purpose: Concurrent checks on the port 2 status and advertisement words.
// Assumes: Sees only the ports of port2_phy_regs; one clock domain.
// Notes:   Read data is judged in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module port2_phy_regs_sva
    import port2_phy_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // Host register port
    input wire logic [7:0]  regAddr,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [1:0]  regBe,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    // Transceiver status
    input wire logic        anComplete,
    input wire logic        linkUp,
    input wire logic        partnerPause,
    input wire logic [3:0]  partnerAbility,
    input wire logic        anEnable,
    // Shared bits and derived outputs
    input wire logic        cw4WrEn,
    input wire logic [4:0]  cw4WrData,
    input wire logic [4:0]  cw4AdvBits,
    input wire logic [6:0]  statusWordMirror,
    input wire logic [4:0]  advertToAn
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Counts the first edges after reset, while the capture flops still hold reset values.
    logic [1:0] upCnt_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) upCnt_reg <= 2'h0;
        else if (upCnt_reg != 2'h3) upCnt_reg <= upCnt_reg + 2'h1;
    end
    wire logic rdBasic = regRdEn && wordHit(regAddr, OFS_BASIC_STATUS);
    wire logic rdAdv   = regRdEn && wordHit(regAddr, OFS_ADVERT);
    wire logic rdPart  = regRdEn && wordHit(regAddr, OFS_PARTNER) && upCnt_reg != 2'h0;
    wire logic rdRsvd  = regRdEn && wordHit(regAddr, OFS_RESERVED_LOC);
    wire logic wrAdv   = regWrEn && wordHit(regAddr, OFS_ADVERT) && regBe == 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    property p_basicFixed; rdBasic |=> (regRdData & 16'hFFDB) == 16'h7808; endproperty
    a_basicFixed: assert property (p_basicFixed) else $error("basic fixed bits wrong");
    property p_anDone; rdBasic && upCnt_reg != 2'h0 |=> regRdData[5] == $past(anComplete, 2); endproperty
    a_anDone: assert property (p_anDone) else $error("negotiation done bit wrong");
    property p_link; rdBasic && upCnt_reg != 2'h0 |=> regRdData[2] == $past(linkUp, 2); endproperty
    a_link: assert property (p_link) else $error("link bit wrong");
    property p_mirror; upCnt_reg[1] |-> statusWordMirror ==
        $past({anComplete, linkUp, partnerPause, partnerAbility}, 2); endproperty
    a_mirror: assert property (p_mirror) else $error("status mirror wrong");
    property p_advFixed; rdAdv |=> regRdData[4:0] == 5'h01 && regRdData[15:11] == 5'h00; endproperty
    a_advFixed: assert property (p_advFixed) else $error("advert fixed bits wrong");
    property p_partner; rdPart |=> (regRdData & 16'hFA1F) == 16'h0001 && regRdData[10] ==
        $past(partnerPause, 2) && regRdData[8:5] == $past(partnerAbility, 2); endproperty
    a_partner: assert property (p_partner) else $error("partner word wrong");
    property p_rsvdLoc; rdRsvd |=> regRdData == 16'h0000; endproperty
    a_rsvdLoc: assert property (p_rsvdLoc) else $error("reserved location not zero");
    property p_hostWr; wrAdv |=> cw4AdvBits == {$past(regWrData[10]), $past(regWrData[8:5])};
    endproperty
    a_hostWr: assert property (p_hostWr) else $error("host write not in shared bits");
    property p_cw4Wr; cw4WrEn && !regWrEn |=> cw4AdvBits == $past(cw4WrData); endproperty
    a_cw4Wr: assert property (p_cw4Wr) else $error("control word write lost");
    property p_anGate; upCnt_reg != 2'h0 |->
        advertToAn == ($past(anEnable) ? $past(cw4AdvBits) : 5'h00); endproperty
    a_anGate: assert property (p_anGate) else $error("advert gating wrong");
endmodule // port2_phy_regs_sva

bind port2_phy_regs port2_phy_regs_sva port2_phy_regs_sva_inst (
    .clk_sys, .rstn, .regAddr, .regWrEn, .regRdEn, .regBe, .regWrData, .regRdData,
    .anComplete, .linkUp, .partnerPause, .partnerAbility, .anEnable,
    .cw4WrEn, .cw4WrData, .cw4AdvBits, .statusWordMirror, .advertToAn
);
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the port 2 status and advertisement words.
// Assumes: Inputs change 1 ns after the rising edge of clk_sys.
// Notes:   Identifier values are arbitrary and chosen here.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import port2_phy_pkg::*;
;
    localparam logic [15:0] ID_LO = 16'h3C96;
    localparam logic [15:0] ID_HI = 16'h0F5A;
    logic        clk_sys = 1'h0;
    logic        rstn = 1'h0;
    logic [7:0]  regAddr = 8'h00;
    logic        regWrEn = 1'h0;
    logic        regRdEn = 1'h0;
    logic [1:0]  regBe = 2'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        anComplete = 1'h0;
    logic        linkUp = 1'h0;
    logic        partnerPause = 1'h0;
    logic [3:0]  partnerAbility = 4'h0;
    logic        anEnable = 1'h1;
    logic        cw4WrEn = 1'h0;
    logic [4:0]  cw4WrData = 5'h00;
    logic [15:0] regRdData;
    logic        regRdValid;
    logic [4:0]  cw4AdvBits;
    logic [6:0]  statusWordMirror;
    logic [4:0]  advertToAn;
    int          fails = 0;
    int          samplesChecked = 0;
    int          cycles = 0;

    port2_phy_regs #(.IDENT_LOW_VALUE(ID_LO), .IDENT_HIGH_VALUE(ID_HI)) port2_phy_regs_inst (
        .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regBe(regBe), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .anComplete(anComplete), .linkUp(linkUp),
        .partnerPause(partnerPause), .partnerAbility(partnerAbility), .anEnable(anEnable),
        .cw4WrEn(cw4WrEn), .cw4WrData(cw4WrData), .cw4AdvBits(cw4AdvBits),
        .statusWordMirror(statusWordMirror), .advertToAn(advertToAn));

    always #4 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (fails == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        regAddr = a;
        regBe = be;
        regWrData = d;
        regWrEn = 1'h1;
        @(posedge clk_sys);
        #1;
        regWrEn = 1'h0;
    endtask

    // Reads one word and judges it, the valid flag included.
    task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        #1;
        regAddr = a;
        regRdEn = 1'h1;
        @(posedge clk_sys);
        #1;
        regRdEn = 1'h0;
        chk({15'h0, regRdValid}, 16'h0001);
        chk(regRdData, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_resetVals();
        rdChk(OFS_BASIC_STATUS, 16'h7808);
        rdChk(OFS_IDENT_LOW, ID_LO);
        rdChk(OFS_IDENT_HIGH, ID_HI);
        rdChk(OFS_ADVERT, 16'h05E1);
        rdChk(OFS_PARTNER, 16'h0001);
        rdChk(OFS_RESERVED_LOC, 16'h0000);
        rdChk(8'h00, 16'h0000);
        chk({11'h0, cw4AdvBits}, 16'h001F);
        chk({11'h0, advertToAn}, 16'h001F);
    endtask

    task automatic t_status();
        logic [6:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 7'h55 : 7'h2A;
            @(posedge clk_sys);
            #1;
            {anComplete, linkUp, partnerPause, partnerAbility} = v;
            rdChk(OFS_BASIC_STATUS, {10'h1E0, v[6], 1'h0, 1'h1, v[5], 2'h0});
            rdChk(OFS_PARTNER, {5'h00, v[4], 1'h0, v[3:0], 5'h01});
            chk({9'h0, statusWordMirror}, {9'h0, v});
            @(posedge clk_sys);
            #1;
            chk({15'h0, regRdValid}, 16'h0000);
            chk(regRdData, {5'h00, v[4], 1'h0, v[3:0], 5'h01});
        end
    endtask

    task automatic t_readOnly();
        logic [7:0]  a [5] = '{OFS_BASIC_STATUS, OFS_IDENT_LOW, OFS_IDENT_HIGH,
                               OFS_PARTNER, OFS_RESERVED_LOC};
        logic [15:0] e [5] = '{16'h780C, ID_LO, ID_HI, 16'h0141, 16'h0000};
        for (int i = 0; i < 5; i++) begin
            wr(a[i], 2'h3, 16'hFFFF);
            rdChk(a[i], e[i]);
        end
        wr(OFS_ADVERT, 2'h3, 16'hF81F);
        rdChk(OFS_ADVERT, 16'h0001);
    endtask

    task automatic t_advert();
        wr(OFS_ADVERT, 2'h3, 16'hFFFF);
        rdChk(OFS_ADVERT, 16'h07E1);
        chk({11'h0, cw4AdvBits}, 16'h001F);
        wr(OFS_ADVERT, 2'h3, 16'h0000);
        rdChk(OFS_ADVERT, 16'h0001);
        chk({11'h0, cw4AdvBits}, 16'h0000);
        wr(OFS_ADVERT, 2'h2, 16'h0500);
        wr(OFS_ADVERT, 2'h0, 16'hFFFF);
        rdChk(OFS_ADVERT, 16'h0501);
        wr(OFS_ADVERT, 2'h1, 16'h00A0);
        rdChk(OFS_ADVERT, 16'h05A1);
        chk({11'h0, advertToAn}, 16'h001D);
        anEnable = 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({11'h0, advertToAn}, 16'h0000);
        anEnable = 1'h1;
    endtask

    task automatic t_cw4();
        @(posedge clk_sys);
        #1;
        cw4WrData = 5'h15;
        cw4WrEn = 1'h1;
        @(posedge clk_sys);
        #1;
        cw4WrEn = 1'h0;
        chk({11'h0, cw4AdvBits}, 16'h0015);
        rdChk(OFS_ADVERT, 16'h04A1);
    endtask

    task automatic t_midReset();
        @(posedge clk_sys);
        #1;
        rstn = 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        rstn = 1'h1;
        rdChk(OFS_ADVERT, 16'h05E1);
        chk({11'h0, cw4AdvBits}, 16'h001F);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        rstn = 1'h1;
        t_resetVals();
        t_status();
        t_readOnly();
        t_advert();
        t_cw4();
        t_midReset();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
